// File: hdl/sram_pkg.sv
// Constants, types and state codes for the serial SRAM command port
// Overview of operation
// - Host lowers CS, then sends an 8-bit instruction before address or data.
// - Read and write take a 24-bit address; only the low 17 bits are kept.
// - After read instruction and address the stored byte is shifted out.
// - Sequential mode advances the pointer per byte, wrapping 1FFFFh to 00000h.
// - In page and sequential modes a read keeps supplying bytes on clocks until the host raises CS.
// - A write is instruction, address, data bytes, ended by CS high.
// - Page mode advances within the 32-byte page, overwriting past its end.
// - Sequential writes past the top wrap and overwrite from address zero.
// - Byte 03h is array read and 02h array write, from the given address.
// - Byte 3Bh received in single-lane mode enters dual-lane mode.
// - Byte FFh returns to single lane, sent in the current lane format.
// - Byte 05h returns the 8-bit mode register, allowed at any time.
// - Byte 01h loads bits 7:6 of the following data byte into the mode register; bits 5:0 are cleared.
// - Mode bits 7:6: 00 byte, 10 page, 01 sequential default, 11 reserved.
// - After power-up no transaction starts before a CS high-to-low transition.
// - CS high deselects, goes to standby and floats the serial output.
// - Input bits are sampled on each rising edge of the serial clock.
// - Output bits change after each falling edge of the serial clock.
// - Dual-lane mode moves two bits per clock, MSB first, for everything.
// - Dual-lane read sends one dummy byte after the address; host drops it.
// - Instructions, addresses and data travel MSB first, LSB last.
// - Byte mode moves exactly one data byte after the address.
// - Page boundary wraps the address to the same page start; 4096 pages.
package sram_pkg;

	// ****************************************
	// Widths and addresses
	// ****************************************
	localparam int ADDR_W = 17;
	localparam int PAGE_W = 5;
	localparam int FIFO_DEPTH = 8;
	localparam logic [16:0] ADDR_ONE = 17'h00001;
	localparam logic [16:0] ADDR_TOP = 17'h1FFFF;
	localparam logic [4:0] PAGE_ONE = 5'h01;
	localparam logic [4:0] PAGE_LAST = 5'h1F;
	localparam logic [1:0] ADDR_LAST = 2'h2;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] STEP_SINGLE = 4'h1;
	localparam logic [3:0] STEP_DUAL = 4'h2;
	localparam logic [3:0] SYNC_RESET = 4'h0;

	// ****************************************
	// Instructions
	// ****************************************
	localparam logic [7:0] CMD_READ = 8'h03;
	localparam logic [7:0] CMD_WRITE = 8'h02;
	localparam logic [7:0] CMD_ENTER_DUAL = 8'h3B;
	localparam logic [7:0] CMD_EXIT_DUAL = 8'hFF;
	localparam logic [7:0] CMD_MODE_RD = 8'h05;
	localparam logic [7:0] CMD_MODE_WR = 8'h01;

	// ****************************************
	// Operating mode register
	// ****************************************
	localparam int MODE_HI = 7;
	localparam int MODE_LO = 6;
	localparam logic [1:0] OP_BYTE = 2'h0;
	localparam logic [1:0] OP_PAGE = 2'h2;
	localparam logic [1:0] OP_SEQ = 2'h1;
	localparam logic [5:0] MODE_RSVD = 6'h00;
	localparam logic [7:0] MODE_RESET = 8'h40;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [2:0] {
		ST_CMD = 3'b000,
		ST_ADDR = 3'b001,
		ST_DUMMY = 3'b010,
		ST_RD = 3'b011,
		ST_WR = 3'b100,
		ST_MRD = 3'b101,
		ST_MWR = 3'b110,
		ST_IGN = 3'b111
	} state_t;

	typedef struct packed {
		logic [16:0] addr;
		logic [7:0] data;
	} wr_entry_t;

endpackage

// File: hdl/serial_sram_command_port.sv
// Write FIFO and serial SRAM command port top level
`timescale 1ns/1ps

// ****************************************
// Write data FIFO
// ****************************************
module wr_fifo #(
	parameter int WIDTH = 25,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_srst,
	// Fill side
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	// Drain side
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW:0] CNT_FULL = (PW+1)'(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0] wp_q;
	logic [PW-1:0] rp_q;
	logic [PW:0] cnt_q;
	wire push = i_in_valid & o_in_ready;
	wire pop = o_out_valid & i_out_ready;

	assign o_in_ready = cnt_q != CNT_FULL;
	assign o_out_valid = cnt_q != '0;
	assign o_out_data = mem_q[rp_q];

	always_ff @(posedge i_ref_clk) begin
		if (push)
			mem_q[wp_q] <= i_in_data;
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			wp_q <= push ? PW'(wp_q + 1'b1) : wp_q;
			rp_q <= pop ? PW'(rp_q + 1'b1) : rp_q;
			cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
		end
	end
endmodule

// ****************************************
// Command port top
// ****************************************
module serial_sram_command_port (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_srst,
	// Serial pins
	input wire logic i_cs_n,
	input wire logic i_sck,
	input wire logic i_lane0,
	output logic o_lane0,
	output logic o_lane0_oe_n,
	input wire logic i_lane1,
	output logic o_lane1,
	output logic o_lane1_oe_n,
	// Array read port
	output logic o_rd_req,
	output logic [16:0] o_rd_addr,
	input wire logic i_rd_valid,
	input wire logic [7:0] i_rd_data,
	// Array write port
	output logic o_wr_valid,
	output sram_pkg::wr_entry_t o_wr_entry,
	input wire logic i_wr_ready,
	// Status
	output logic [7:0] o_operating_mode,
	output logic o_dual_lane_mode,
	output logic o_wr_fifo_full
);
	// ****************************************
	// Pin synchronisers and edges
	// ****************************************
	logic [3:0] s1_q;
	logic [3:0] s2_q;
	logic sck3_q;
	logic armed_q;

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			s1_q <= sram_pkg::SYNC_RESET;
			s2_q <= sram_pkg::SYNC_RESET;
			sck3_q <= 1'b0;
		end else begin
			s1_q <= {i_cs_n, i_sck, i_lane1, i_lane0};
			s2_q <= s1_q;
			sck3_q <= s2_q[2];
		end
	end

	wire cs_high = s2_q[3];
	wire sck = s2_q[2];
	wire lane1_in = s2_q[1];
	wire lane0_in = s2_q[0];
	wire rise = sck & ~sck3_q;
	wire fall = ~sck & sck3_q;
	wire active = armed_q & ~cs_high;

	// Armed only once CS was seen high after reset
	always_ff @(posedge i_ref_clk) begin
		if (i_srst)
			armed_q <= 1'b0;
		else if (cs_high)
			armed_q <= 1'b1;
	end

	// ****************************************
	// Input shifter
	// ****************************************
	sram_pkg::state_t state_q;
	sram_pkg::state_t state_d;
	logic dual_q;
	logic [7:0] mode_q;
	logic [7:0] in_q;
	logic [3:0] cnt_q;
	logic [1:0] bc_q;
	logic rd_q;
	logic [16:0] addr_q;

	wire [3:0] step = dual_q ? sram_pkg::STEP_DUAL : sram_pkg::STEP_SINGLE;
	wire [7:0] in_next = dual_q ? {in_q[5:0], lane1_in, lane0_in}
		: {in_q[6:0], lane0_in};
	wire [3:0] cnt_sum = cnt_q + step;
	wire byte_done = rise & active & (cnt_sum == sram_pkg::BYTE_BITS);
	wire cmd_done = byte_done & (state_q == sram_pkg::ST_CMD);
	wire addr_done = byte_done & (state_q == sram_pkg::ST_ADDR)
		& (bc_q == sram_pkg::ADDR_LAST);
	wire [16:0] addr_new = {addr_q[8:0], in_next};

	always_ff @(posedge i_ref_clk) begin
		if (i_srst || !active) begin
			cnt_q <= '0;
			bc_q <= '0;
		end else if (rise) begin
			cnt_q <= byte_done ? '0 : cnt_sum;
			if (byte_done && state_q == sram_pkg::ST_ADDR)
				bc_q <= bc_q + 2'h1;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst)
			in_q <= '0;
		else if (rise && active)
			in_q <= in_next;
	end

	// ****************************************
	// Address pointer
	// ****************************************
	wire [1:0] op = mode_q[sram_pkg::MODE_HI:sram_pkg::MODE_LO];
	wire is_byte = op == sram_pkg::OP_BYTE;
	wire is_page = op == sram_pkg::OP_PAGE;
	wire [4:0] page_inc = addr_q[sram_pkg::PAGE_W-1:0] + sram_pkg::PAGE_ONE;
	wire [16:0] addr_adv = is_page
		? {addr_q[sram_pkg::ADDR_W-1:sram_pkg::PAGE_W], page_inc}
		: addr_q + sram_pkg::ADDR_ONE;
	logic [2:0] ocnt_q;
	logic loaded_q;
	wire drive_st = state_q == sram_pkg::ST_RD || state_q == sram_pkg::ST_MRD;
	wire rd_stop = fall & active & (state_q == sram_pkg::ST_RD) & is_byte
		& loaded_q & (ocnt_q == '0);
	wire load = fall & active & drive_st & (ocnt_q == '0) & ~rd_stop;
	wire rd_next = load & (state_q == sram_pkg::ST_RD);
	logic fifo_in_ready;
	wire wr_byte = byte_done & (state_q == sram_pkg::ST_WR);
	wire push = wr_byte & fifo_in_ready;

	always_ff @(posedge i_ref_clk) begin
		if (i_srst)
			addr_q <= '0;
		else if (byte_done && state_q == sram_pkg::ST_ADDR)
			addr_q <= addr_new;
		else if (wr_byte || rd_next)
			addr_q <= addr_adv;
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst)
			rd_q <= 1'b0;
		else if (cmd_done)
			rd_q <= in_next == sram_pkg::CMD_READ;
	end

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb begin
		state_d = state_q;
		if (!active)
			state_d = sram_pkg::ST_CMD;
		else if (rd_stop)
			state_d = sram_pkg::ST_IGN;
		else if (byte_done) begin
			case (state_q)
				sram_pkg::ST_CMD: begin
					case (in_next)
						sram_pkg::CMD_READ: state_d = sram_pkg::ST_ADDR;
						sram_pkg::CMD_WRITE: state_d = sram_pkg::ST_ADDR;
						sram_pkg::CMD_MODE_RD: state_d = sram_pkg::ST_MRD;
						sram_pkg::CMD_MODE_WR: state_d = sram_pkg::ST_MWR;
						default: state_d = sram_pkg::ST_IGN;
					endcase
				end
				sram_pkg::ST_ADDR: begin
					if (addr_done && !rd_q)
						state_d = sram_pkg::ST_WR;
					else if (addr_done)
						state_d = dual_q ? sram_pkg::ST_DUMMY
							: sram_pkg::ST_RD;
				end
				sram_pkg::ST_DUMMY: state_d = sram_pkg::ST_RD;
				sram_pkg::ST_WR: begin
					if (is_byte)
						state_d = sram_pkg::ST_IGN;
				end
				sram_pkg::ST_MWR: state_d = sram_pkg::ST_IGN;
				default: state_d = state_q;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst)
			state_q <= sram_pkg::ST_CMD;
		else
			state_q <= state_d;
	end

	// ****************************************
	// Mode and lane registers
	// ****************************************
	always_ff @(posedge i_ref_clk) begin
		if (i_srst)
			mode_q <= sram_pkg::MODE_RESET;
		else if (byte_done && state_q == sram_pkg::ST_MWR)
			mode_q <= {in_next[7:6], sram_pkg::MODE_RSVD};
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst)
			dual_q <= 1'b0;
		else if (cmd_done && in_next == sram_pkg::CMD_ENTER_DUAL)
			dual_q <= 1'b1;
		else if (cmd_done && in_next == sram_pkg::CMD_EXIT_DUAL)
			dual_q <= 1'b0;
	end

	// ****************************************
	// Array read and output shifter
	// ****************************************
	logic rd_req_q;
	logic [16:0] rd_addr_q;
	logic [7:0] pre_q;
	logic [7:0] out_q;
	logic lane0_oe_n_q;
	logic lane1_oe_n_q;
	wire [7:0] load_src = state_q == sram_pkg::ST_MRD ? mode_q : pre_q;
	wire [7:0] out_shift = dual_q ? {out_q[5:0], 2'b00} : {out_q[6:0], 1'b0};
	wire drive = active & loaded_q & drive_st;

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			rd_req_q <= 1'b0;
			rd_addr_q <= '0;
		end else begin
			rd_req_q <= (addr_done & rd_q) | rd_next;
			if (addr_done)
				rd_addr_q <= addr_new;
			else if (rd_next)
				rd_addr_q <= addr_adv;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst)
			pre_q <= '0;
		else if (i_rd_valid)
			pre_q <= i_rd_data;
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			out_q <= '0;
			ocnt_q <= '0;
			loaded_q <= 1'b0;
		end else if (!active) begin
			ocnt_q <= '0;
			loaded_q <= 1'b0;
		end else if (fall && drive_st && !rd_stop) begin
			out_q <= load ? load_src : out_shift;
			ocnt_q <= ocnt_q + step[2:0];
			loaded_q <= 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			lane0_oe_n_q <= 1'b1;
			lane1_oe_n_q <= 1'b1;
		end else begin
			lane1_oe_n_q <= ~drive;
			lane0_oe_n_q <= ~(drive & dual_q);
		end
	end

	// ****************************************
	// Write path
	// ****************************************
	sram_pkg::wr_entry_t fifo_out;
	sram_pkg::wr_entry_t wr_entry_q;
	logic fifo_out_valid;
	logic wr_valid_q;
	logic full_q;
	wire drain = ~wr_valid_q | i_wr_ready;
	wire pop = fifo_out_valid & drain;

	wr_fifo #(
		.WIDTH($bits(sram_pkg::wr_entry_t)),
		.DEPTH(sram_pkg::FIFO_DEPTH)
	) u_fifo (
		.i_ref_clk(i_ref_clk),
		.i_srst(i_srst),
		.i_in_valid(wr_byte),
		.o_in_ready(fifo_in_ready),
		.i_in_data({addr_q, in_next}),
		.o_out_valid(fifo_out_valid),
		.i_out_ready(drain),
		.o_out_data(fifo_out)
	);

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			wr_valid_q <= 1'b0;
			wr_entry_q <= '0;
			full_q <= 1'b0;
		end else begin
			full_q <= ~fifo_in_ready;
			if (pop) begin
				wr_valid_q <= 1'b1;
				wr_entry_q <= fifo_out;
			end else if (i_wr_ready)
				wr_valid_q <= 1'b0;
		end
	end

	assign o_lane0 = out_q[6];
	assign o_lane1 = out_q[7];
	assign o_lane0_oe_n = lane0_oe_n_q;
	assign o_lane1_oe_n = lane1_oe_n_q;
	assign o_rd_req = rd_req_q;
	assign o_rd_addr = rd_addr_q;
	assign o_wr_valid = wr_valid_q;
	assign o_wr_entry = wr_entry_q;
	assign o_operating_mode = mode_q;
	assign o_dual_lane_mode = dual_q;
	assign o_wr_fifo_full = full_q;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_srst);

	property p_tristate;
		cs_high |=> ##1 (lane1_oe_n_q && lane0_oe_n_q);
	endproperty
	a_tristate: assert property (p_tristate)
		else $error("output driven while deselected");

	property p_seq_wrap;
		rd_next && !is_page && addr_q == sram_pkg::ADDR_TOP
			|=> addr_q == '0;
	endproperty
	a_seq_wrap: assert property (p_seq_wrap)
		else $error("sequential pointer did not wrap");

	property p_page_wrap;
		(wr_byte || rd_next) && is_page
			&& addr_q[4:0] == sram_pkg::PAGE_LAST
			|=> addr_q[4:0] == '0 && $stable(addr_q[16:5]);
	endproperty
	a_page_wrap: assert property (p_page_wrap)
		else $error("page pointer left its page");

	property p_read_cmd;
		cmd_done && in_next == sram_pkg::CMD_READ
			|=> state_q == sram_pkg::ST_ADDR && rd_q;
	endproperty
	a_read_cmd: assert property (p_read_cmd)
		else $error("read instruction not decoded");

	property p_enter_dual;
		cmd_done && in_next == sram_pkg::CMD_ENTER_DUAL |=> dual_q;
	endproperty
	a_enter_dual: assert property (p_enter_dual)
		else $error("dual lane not entered");

	property p_exit_dual;
		cmd_done && in_next == sram_pkg::CMD_EXIT_DUAL |=> !dual_q;
	endproperty
	a_exit_dual: assert property (p_exit_dual)
		else $error("dual lane not left");

	property p_mode_wr;
		byte_done && state_q == sram_pkg::ST_MWR
			|=> mode_q[7:6] == $past(in_next[7:6]);
	endproperty
	a_mode_wr: assert property (p_mode_wr)
		else $error("mode register not loaded");

	property p_mode_rsvd;
		mode_q[5:0] == sram_pkg::MODE_RSVD;
	endproperty
	a_mode_rsvd: assert property (p_mode_rsvd)
		else $error("reserved mode bits set");

	property p_out_on_fall;
		!$stable(out_q) |-> $past(fall);
	endproperty
	a_out_on_fall: assert property (p_out_on_fall)
		else $error("output changed off a falling edge");

	property p_ignore;
		state_q == sram_pkg::ST_IGN && active |=> state_q == sram_pkg::ST_IGN;
	endproperty
	a_ignore: assert property (p_ignore)
		else $error("ignored transaction resumed");

	property p_abort;
		cs_high |=> state_q == sram_pkg::ST_CMD && cnt_q == '0;
	endproperty
	a_abort: assert property (p_abort)
		else $error("deselect did not abort");

	c_read: cover property (rd_next ##[1:1000] rd_next);
	c_write: cover property (push ##[1:1000] push);
	c_dual: cover property (state_q == sram_pkg::ST_DUMMY);
	c_full: cover property (full_q);
endmodule

// File: verif/host_model.sv
// Host controller model driving the serial pins
`timescale 1ns/1ps

module host_model (
	// Clock
	input wire logic i_ref_clk,
	// Resolved lane levels
	input wire logic i_w0,
	input wire logic i_w1,
	// Pins driven by the host
	output logic o_cs_n,
	output logic o_sck,
	output logic o_h0,
	output logic o_h1
);
	int half = 20;

	initial begin
		o_cs_n = 1'b0;
		o_sck = 1'b0;
		o_h0 = 1'b0;
		o_h1 = 1'b1;
	end

	task automatic wt(input int n);
		repeat (n) @(posedge i_ref_clk);
	endtask

	// ********
	// Framing, clock idle low
	// ********
	task automatic start();
		wt(4);
		o_cs_n <= 1'b0;
		wt(half);
	endtask

	task automatic stop();
		wt(half);
		o_cs_n <= 1'b1;
		wt(12);
	endtask

	// One unit, MSB first; released lanes toggle
	task automatic xfer(input logic [7:0] tx, input bit dual,
		input bit drv, output logic [7:0] rx, input int nb = 8);
		int i;
		rx = 8'h00;
		for (i = 0; i < nb; i = i + (dual ? 2 : 1)) begin
			if (!drv) begin
				o_h0 <= ~o_h0;
				o_h1 <= ~o_h1;
			end else if (dual) begin
				o_h1 <= tx[7-i];
				o_h0 <= tx[6-i];
			end else begin
				o_h0 <= tx[7-i];
				o_h1 <= ~o_h1;
			end
			wt(half);
			o_sck <= 1'b1;
			rx = dual ? {rx[5:0], i_w1, i_w0} : {rx[6:0], i_w1};
			wt(half);
			o_sck <= 1'b0;
		end
	endtask
endmodule

// File: verif/tb.sv
// Testbench for the serial SRAM command port
`timescale 1ns/1ps

module tb;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic cs_n, sck, h0, h1, w0, w1, o0, o0e, o1, o1e;
	logic rd_req, wr_valid, dual, full;
	logic rd_valid = 1'b0;
	logic wr_ready = 1'b1;
	logic [16:0] rd_addr;
	logic [7:0] rd_data = 8'h00;
	logic [7:0] mode, rx;
	logic [1:0] om = 2'h1;
	sram_pkg::wr_entry_t ent;
	logic [7:0] mem [0:131071];
	logic [7:0] exp_m [0:131071];
	int n_fail = 0;
	int n_tests = 0;
	int cyc = 0;
	int lat = 1;
	int cnt = 0;
	bit dm = 1'b0;

	always #2 clk = ~clk;
	assign w0 = (o0e === 1'b0) ? o0 : h0;
	assign w1 = (o1e === 1'b0) ? o1 : h1;

	serial_sram_command_port u_dut (
		.i_ref_clk(clk), .i_srst(srst), .i_cs_n(cs_n), .i_sck(sck),
		.i_lane0(w0), .o_lane0(o0), .o_lane0_oe_n(o0e),
		.i_lane1(w1), .o_lane1(o1), .o_lane1_oe_n(o1e),
		.o_rd_req(rd_req), .o_rd_addr(rd_addr), .i_rd_valid(rd_valid),
		.i_rd_data(rd_data), .o_wr_valid(wr_valid), .o_wr_entry(ent),
		.i_wr_ready(wr_ready), .o_operating_mode(mode),
		.o_dual_lane_mode(dual), .o_wr_fifo_full(full)
	);

	host_model u_host (
		.i_ref_clk(clk), .i_w0(w0), .i_w1(w1), .o_cs_n(cs_n),
		.o_sck(sck), .o_h0(h0), .o_h1(h1)
	);

	// ********
	// Array model
	// ********
	always @(posedge clk) begin
		rd_valid <= (cnt == 1);
		if (cnt == 1)
			rd_data <= mem[rd_addr];
		if (rd_req)
			cnt <= lat;
		else if (cnt != 0)
			cnt <= cnt - 1;
		if (wr_valid && wr_ready)
			mem[ent.addr] <= ent.data;
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			n_fail++;
			print_verdict();
		end
	end

	function automatic logic [7:0] pat(input logic [16:0] a);
		return a[7:0] ^ a[16:9];
	endfunction

	function automatic logic [16:0] nxt(input logic [16:0] a);
		if (om == sram_pkg::OP_PAGE)
			return {a[16:5], a[4:0] + 5'h01};
		return a + 17'h00001;
	endfunction

	// ********
	// Compare and report
	// ********
	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic chkb(input string nm, input logic e, input logic g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s exp %b got %b", nm, e, g);
		end
	endtask

	task automatic print_verdict();
		$display("tests %0d failures %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ********
	// Access tasks
	// ********
	task automatic hdr(input logic [7:0] c, input logic [23:0] ad);
		int k;
		u_host.start();
		u_host.xfer(c, dm, 1'b1, rx);
		for (k = 2; k >= 0; k--)
			u_host.xfer(ad[8*k +: 8], dm, 1'b1, rx);
	endtask

	task automatic one(input logic [7:0] c);
		u_host.start();
		u_host.xfer(c, dm, 1'b1, rx);
		u_host.stop();
	endtask

	task automatic drain();
		int i;
		for (i = 0; i < 300 && wr_valid !== 1'b0; i++)
			@(posedge clk);
		chkb("wr_idle", 1'b0, wr_valid);
	endtask

	task automatic wr(input logic [23:0] ad, input logic [7:0] d,
		input int n);
		logic [16:0] a;
		int i;
		a = ad[16:0];
		hdr(sram_pkg::CMD_WRITE, ad);
		for (i = 0; i < n; i++) begin
			u_host.xfer(d + i[7:0], dm, 1'b1, rx);
			if (i == 0 || om != sram_pkg::OP_BYTE)
				exp_m[a] = d + i[7:0];
			a = nxt(a);
		end
		u_host.stop();
		if (wr_ready)
			drain();
	endtask

	task automatic rd(input logic [23:0] ad, input int n);
		logic [16:0] a;
		int i;
		a = ad[16:0];
		hdr(sram_pkg::CMD_READ, ad);
		if (dm)
			u_host.xfer(8'h00, 1'b1, 1'b0, rx);
		for (i = 0; i < n; i++) begin
			u_host.xfer(8'h00, dm, 1'b0, rx);
			chk("rd_data", exp_m[a], rx);
			a = nxt(a);
		end
		if (om == sram_pkg::OP_BYTE) begin
			u_host.xfer(8'h00, dm, 1'b0, rx);
			chkb("so_oe_n", 1'b1, o1e);
		end
		u_host.stop();
		chkb("oe_n", 1'b1, o1e & o0e);
	endtask

	task automatic mw(input logic [7:0] v);
		one(sram_pkg::CMD_MODE_WR);
		hdr(sram_pkg::CMD_MODE_WR, {v, 16'h0000});
		u_host.stop();
		om = v[7:6];
		chk("opmode", v, mode);
		u_host.start();
		u_host.xfer(sram_pkg::CMD_MODE_RD, dm, 1'b1, rx);
		u_host.xfer(8'h00, dm, 1'b0, rx);
		chk("mode_rd", v, rx);
		u_host.stop();
	endtask

	// ********
	// Test sequence
	// ********
	initial begin
		for (int i = 0; i < 131072; i++) begin
			mem[i] = pat(i[16:0]);
			exp_m[i] = pat(i[16:0]);
		end
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		hdr(sram_pkg::CMD_WRITE, 24'h000040);
		u_host.xfer(8'h5A, 1'b0, 1'b1, rx);
		u_host.stop();
		chk("mode_rst", 8'h40, mode);
		chkb("dual_rst", 1'b0, dual);
		rd(24'h000040, 1);
		wr(24'hFFFFFF, 8'h11, 3);
		lat = 10;
		rd(24'hFFFFFF, 3);
		lat = 1;
		wr_ready <= 1'b0;
		wr(24'h000100, 8'h20, 10);
		chkb("fifo_full", 1'b1, full);
		exp_m[17'h00109] = pat(17'h00109);
		wr_ready <= 1'b1;
		drain();
		chkb("fifo_full", 1'b0, full);
		rd(24'h000100, 10);
		mw(8'h80);
		wr(24'h00023E, 8'h31, 3);
		rd(24'h00023F, 3);
		mw(8'h00);
		wr(24'h000300, 8'h77, 2);
		rd(24'h000300, 1);
		mw(8'hC0);
		mw(8'h40);
		hdr(8'hA5, 24'h020004);
		u_host.xfer(8'hAA, 1'b0, 1'b1, rx);
		u_host.xfer(8'hBB, 1'b0, 1'b1, rx);
		u_host.stop();
		rd(24'h0004AA, 1);
		hdr(sram_pkg::CMD_WRITE, 24'h000500);
		u_host.xfer(8'h61, 1'b0, 1'b1, rx);
		exp_m[17'h00500] = 8'h61;
		u_host.xfer(8'h62, 1'b0, 1'b1, rx, 4);
		u_host.stop();
		drain();
		rd(24'h000500, 2);
		one(sram_pkg::CMD_ENTER_DUAL);
		chkb("dual", 1'b1, dual);
		dm = 1'b1;
		wr(24'h000600, 8'h90, 2);
		rd(24'h000600, 2);
		one(sram_pkg::CMD_EXIT_DUAL);
		chkb("dual", 1'b0, dual);
		dm = 1'b0;
		rd(24'h000600, 2);
		print_verdict();
	end
endmodule
